// *** logic/wrs_map.svh ***
// Purpose : Timing constants for the watchdog and reset supervisor
// Assumes : Core clock of 125 MHz
// Notes   : Cycle counts are derived from the printed times
`ifndef WRS_MAP_SVH
`define WRS_MAP_SVH

// Clock rate in kHz (period 8 ns)
`define WRS_CLK_KHZ        32'd125000
// Watchdog timeout period, nominal 1.6 s, legal 1.0 s to 2.25 s
`define WRS_WD_PERIOD_MS   32'd1600
`define WRS_WD_CYCLES      (`WRS_WD_PERIOD_MS * `WRS_CLK_KHZ)
// Reset hold period after both reset causes clear
`define WRS_HOLD_MS        32'd200
`define WRS_HOLD_CYCLES    (`WRS_HOLD_MS * `WRS_CLK_KHZ)
// Shortest kick pulse that must be seen, rounded up to whole cycles
`define WRS_KICK_PULSE_NS  32'd100
`define WRS_KICK_CYCLES    ((`WRS_KICK_PULSE_NS * `WRS_CLK_KHZ \
                            + 32'd999999) / 32'd1000000)
// Reset values of the synchronised pins
`define WRS_MR_RST_VAL     1'b1
// Supply taken as good in reset, so the watchdog output does not dip
`define WRS_LOW_RST_VAL    1'b0

`endif

// *** logic/wrs_pkg.sv ***
// Purpose : Types for the watchdog and reset supervisor
// Assumes : Nothing beyond SystemVerilog
// Notes   : Reset sequencer states are Gray coded along the usual path
package wrs_pkg;

	// Reset sequencer: asserted -> holding -> running
	typedef enum logic [1:0] {
		WRS_ST_ASSERT = 2'b00,
		WRS_ST_HOLD   = 2'b01,
		WRS_ST_RUN    = 2'b11
	} wrs_rst_state_t;

endpackage

// *** logic/wrs_supervisor.sv ***
// Purpose : Watchdog timer, reset sequencer and power-fail pass-through
// Assumes : 125 MHz core clock; all pin inputs asynchronous to it
// Notes   : Watchdog output only resets the system if wired back externally
`timescale 1ns/1ps
`include "wrs_map.svh"

module wrs_supervisor
	import wrs_pkg::*;
#(
	parameter int unsigned CNT_W       = 28,
	parameter int unsigned WD_CYCLES   = `WRS_WD_CYCLES,
	parameter int unsigned HOLD_CYCLES = `WRS_HOLD_CYCLES
) (
	input  wire logic clock,              // Core clock, 125 MHz
	input  wire logic resetn,             // Async reset, active low
	input  wire logic watchdog_kick_in,   // Processor activity line
	input  wire logic manual_reset_n,     // Manual reset, active low
	input  wire logic supply_low_in,      // Supply below threshold, high
	input  wire logic supply_warn_in,     // Power-fail comparator tripped
	output logic      watchdog_timeout_n, // Watchdog expired, active low
	output logic      sys_rst_low,        // System reset, active low
	output logic      sys_rst_high,       // System reset, active high
	output logic      supply_warn_n       // Power-fail warning, active low
);

	//--------------------------------------------------------------
	// Pin synchronisation
	//--------------------------------------------------------------

	// Reset levels: no warning, manual reset idle, supply good, kick low
	localparam logic [3:0] SYNC_RST = {1'b0, `WRS_MR_RST_VAL,
	                                   `WRS_LOW_RST_VAL, 1'b0};
	localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_CYCLES - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

	logic [3:0]       pins_s;
	logic             kick_s;
	logic             mr_s;
	logic             supply_low_s;
	logic             warn_s;
	logic             kick_prev_q;
	logic             kick_edge;
	logic             rst_cause;
	logic [CNT_W-1:0] wd_cnt_q;
	logic [CNT_W-1:0] hold_cnt_q;
	logic             wd_expired_q;
	wrs_rst_state_t   rst_state_q;

	// Every pin except resetn passes two flops before use
	wrs_sync #(
		.W       (4),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.async_in ({supply_warn_in, manual_reset_n,
		            supply_low_in, watchdog_kick_in}),
		.sync_out (pins_s)
	);

	assign kick_s       = pins_s[0];
	assign supply_low_s = pins_s[1];
	assign mr_s         = pins_s[2];
	assign warn_s       = pins_s[3];

	//--------------------------------------------------------------
	// Watchdog timer
	//--------------------------------------------------------------

	// Previous synchronised kick level for edge detection
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			kick_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= kick_s;
		end
	end

	// Both edges count, so any pulse wider than a cycle restarts
	assign kick_edge = kick_s ^ kick_prev_q;

	// Tick counter since the last kick edge
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wd_cnt_q <= '0;
		end else if (supply_low_s || kick_edge) begin
			wd_cnt_q <= '0;
		end else if (wd_cnt_q != WD_LAST) begin
			wd_cnt_q <= wd_cnt_q + 1'b1;
		end
	end

	// Expired flag; a later kick edge clears it
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wd_expired_q <= 1'b0;
		end else if (supply_low_s || kick_edge) begin
			wd_expired_q <= 1'b0;
		end else if (wd_cnt_q == WD_LAST) begin
			wd_expired_q <= 1'b1;
		end
	end

	// Watchdog output; supply low overrides at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			watchdog_timeout_n <= 1'b1;
		end else if (supply_low_s) begin
			watchdog_timeout_n <= 1'b0;
		end else if (kick_edge) begin
			watchdog_timeout_n <= 1'b1;
		end else if (wd_cnt_q == WD_LAST || wd_expired_q) begin
			watchdog_timeout_n <= 1'b0;
		end else begin
			watchdog_timeout_n <= 1'b1;
		end
	end

	//--------------------------------------------------------------
	// Reset sequencer
	//--------------------------------------------------------------

	// Watchdog resets reach here only via the external loop to manual
	assign rst_cause = supply_low_s || !mr_s;

	// Assert, then hold for the reset period once causes clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_state_q <= WRS_ST_ASSERT;
		end else if (rst_cause) begin
			rst_state_q <= WRS_ST_ASSERT;
		end else begin
			unique case (rst_state_q)
				WRS_ST_ASSERT: begin
					rst_state_q <= WRS_ST_HOLD;
				end
				WRS_ST_HOLD: begin
					if (hold_cnt_q == HOLD_LAST) begin
						rst_state_q <= WRS_ST_RUN;
					end
				end
				WRS_ST_RUN: begin
					rst_state_q <= WRS_ST_RUN;
				end
				default: begin
					rst_state_q <= WRS_ST_ASSERT;
				end
			endcase
		end
	end

	// Hold period counter, restarted by any new cause
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hold_cnt_q <= '0;
		end else if (rst_state_q != WRS_ST_HOLD || rst_cause) begin
			hold_cnt_q <= '0;
		end else begin
			hold_cnt_q <= hold_cnt_q + 1'b1;
		end
	end

	// Complementary reset outputs from one next-state term
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sys_rst_low  <= 1'b0;
			sys_rst_high <= 1'b1;
		end else begin
			sys_rst_low  <= !rst_cause
			                && rst_state_q == WRS_ST_RUN;
			sys_rst_high <= rst_cause
			                || rst_state_q != WRS_ST_RUN;
		end
	end

	//--------------------------------------------------------------
	// Power-fail pass-through
	//--------------------------------------------------------------

	// Independent of every other function
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			supply_warn_n <= 1'b1;
		end else begin
			supply_warn_n <= !warn_s;
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------

	sequence s_cause_clears;
		$fell(rst_cause);
	endsequence

	sequence s_held_low;
		!sys_rst_low [*8];
	endsequence

	a_kick_restart: assert property (@(posedge clock) disable iff (!resetn)
		kick_edge |=> wd_cnt_q == '0)
		else $error("kick edge did not restart watchdog count");

	a_wdo_expire: assert property (@(posedge clock) disable iff (!resetn)
		(wd_cnt_q == WD_LAST && !kick_edge && !supply_low_s)
		|=> !watchdog_timeout_n)
		else $error("watchdog did not expire at period end");

	a_wdo_kicked: assert property (@(posedge clock) disable iff (!resetn)
		(kick_edge && !supply_low_s) |=> watchdog_timeout_n)
		else $error("watchdog output low despite kick");

	a_period_bound: assert property (@(posedge clock) disable iff (!resetn)
		(!watchdog_timeout_n && !$past(supply_low_s))
		|-> $past(wd_cnt_q) == WD_LAST || $past(wd_expired_q))
		else $error("watchdog expired before full period");

	a_supply_forces: assert property (@(posedge clock) disable iff (!resetn)
		supply_low_s |=> !watchdog_timeout_n && wd_cnt_q == '0)
		else $error("supply low did not force watchdog low");

	a_rst_cause: assert property (@(posedge clock) disable iff (!resetn)
		rst_cause |=> !sys_rst_low)
		else $error("reset not asserted for active cause");

	a_rst_hold: assert property (@(posedge clock) disable iff (!resetn)
		s_cause_clears |-> s_held_low)
		else $error("reset released too soon after cause cleared");

	a_hold_end: assert property (@(posedge clock) disable iff (!resetn)
		(rst_state_q == WRS_ST_HOLD && hold_cnt_q == HOLD_LAST && !rst_cause)
		|=> ##1 sys_rst_low || $past(rst_cause))
		else $error("reset not released after hold period");

	a_rst_compl: assert property (@(posedge clock) disable iff (!resetn)
		sys_rst_high == !sys_rst_low)
		else $error("reset outputs not complementary");

	a_warn_pass: assert property (@(posedge clock) disable iff (!resetn)
		##1 supply_warn_n == !$past(warn_s))
		else $error("power-fail output not following comparator");

endmodule

// *** logic/wrs_sync.sv ***
// Purpose : Two flip-flop synchroniser for asynchronous pins
// Assumes : Inputs may change at any time relative to clock
// Notes   : The first stage is read by the second stage only
`timescale 1ns/1ps

module wrs_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clock,   // Core clock
	input  wire logic         resetn,  // Async reset, active low
	input  wire logic [W-1:0] async_in, // Pin levels
	output logic      [W-1:0] sync_out  // Synchronised levels
);

	logic [W-1:0] meta_q;

	// Two stages per bit
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// *** verif/test_wrs_supervisor.sv ***
// Purpose : Self-checking bench for the watchdog and reset supervisor
// Assumes : Short periods set by parameter for a brief run
// Notes   : Windows allow for the pin synchroniser latency
`timescale 1ns/1ps

module test_wrs_supervisor;
	localparam int WD = 50;
	localparam int HD = 20;
	logic       clock, resetn, kick, mr_drv, loop, slow, warn;
	logic       kp = 1'b0;
	logic       wdo, rl, rh, wn;
	logic [7:0] gap;
	int         num_errors = 0, cmp_count = 0, since = 0, s;
	wire logic  mr = loop ? wdo : mr_drv;

	wrs_host wrs_host_inst (.clock(clock), .gap(gap), .kick(kick));
	wrs_supervisor #(.WD_CYCLES(WD), .HOLD_CYCLES(HD)) wrs_supervisor_inst (
		.clock(clock), .resetn(resetn), .watchdog_kick_in(kick),
		.manual_reset_n(mr), .supply_low_in(slow), .supply_warn_in(warn),
		.watchdog_timeout_n(wdo), .sys_rst_low(rl), .sys_rst_high(rh),
		.supply_warn_n(wn));

	// Clock and watchdog
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		#(8 * 20000);
		num_errors++;
		print_verdict();
	end
	// Cycles since the last kick change, and complement check
	always @(negedge clock) begin
		since <= (kick !== kp) ? 0 : since + 1;
		kp <= kick;
		chk("sys_rst_high", ~rl, rh);
	end

	function logic exp_warn(input logic v);
		return ~v;
	endfunction
	function logic pick(input int k);
		return k == 0 ? wdo : (k == 1 ? rl : wn);
	endfunction
	task chk(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Level must be reached after lo to hi cycles
	task win(input string nm, input int k, input logic v, input int lo,
		input int hi);
		int c;
		c = 0;
		while (pick(k) !== v && c <= hi) begin
			@(negedge clock);
			c++;
		end
		chk(nm, 1'b1, c >= lo && c <= hi);
	endtask
	task stay(input string nm, input int k, input logic v, input int n);
		repeat (n) begin
			@(negedge clock);
			chk(nm, v, pick(k));
		end
	endtask
	task print_verdict();
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		resetn = 1'b0; mr_drv = 1'b1; loop = 1'b0; slow = 1'b0;
		warn = 1'b0; gap = 8'h05;
		s = $urandom(32'h59A61E40);
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		chk("sys_rst_low", 1'b0, rl);
		win("reset hold", 1, 1'b1, HD - 2, HD + 6);
		$display("test reset done");
		// Random kick gaps, 100 ns pulses and the longest gap
		for (int i = 0; i < 30; i++) begin
			// Host reads gap on this edge, so change it after the edge
			gap <= i == 0 ? 8'(WD - 8)
			     : (i == 1 ? 8'h0C : 8'($urandom_range(WD - 8, 1)));
			stay("wdo kicked", 0, 1'b1, 60);
		end
		gap <= 8'h00;
		win("wdo expiry", 0, 1'b0, 1, WD + 60);
		chk("period", 1'b1, since >= WD && since <= WD + 6);
		gap <= 8'h03;
		win("wdo kick back", 0, 1'b1, 1, 8);
		$display("test watchdog done");
		// Manual reset pulses, last one restarts the hold
		for (int i = 0; i < 3; i++) begin
			mr_drv = 1'b0;
			win("mr assert", 1, 1'b0, 1, 4);
			repeat ($urandom_range(13, 3)) @(negedge clock);
			mr_drv = 1'b1;
			if (i == 2) begin
				stay("hold kept", 1, 1'b0, HD / 2);
				mr_drv = 1'b0;
				repeat (4) @(negedge clock);
				mr_drv = 1'b1;
			end
			win("mr hold", 1, 1'b1, HD, HD + 6);
		end
		$display("test manual reset done");
		slow = 1'b1;
		win("wdo supply", 0, 1'b0, 1, 4);
		chk("rst supply", 1'b0, rl);
		stay("kick ignored", 0, 1'b0, 100);
		slow = 1'b0;
		win("supply hold", 1, 1'b1, HD, HD + 6);
		chk("wdo restore", 1'b1, wdo);
		$display("test supply low done");
		// Warning follows its comparator only
		for (int i = 0; i < 16; i++) begin
			warn = 1'($urandom);
			mr_drv = 1'($urandom);
			slow = 1'($urandom);
			repeat (5) @(negedge clock);
			chk("supply_warn_n", exp_warn(warn), wn);
		end
		mr_drv = 1'b1;
		slow = 1'b0;
		win("warn idle", 1, 1'b1, 0, HD + 8);
		$display("test warning done");
		loop = 1'b1;
		gap <= 8'h00;
		win("wd reset", 1, 1'b0, WD, WD + 20);
		gap <= 8'h03;
		win("wd reset end", 1, 1'b1, HD, HD + 14);
		loop = 1'b0;
		$display("test loop done");
		print_verdict();
	end
endmodule

// *** verif/wrs_host.sv ***
// Purpose : Host processor model that kicks the watchdog
// Assumes : Kick level changes just after the falling clock edge
// Notes   : A gap of zero keeps the kick line still
`timescale 1ns/1ps

module wrs_host (
	input  wire logic       clock, // Core clock
	input  wire logic [7:0] gap,   // Cycles between kicks, less one
	output logic            kick   // Kick line
);
	int   n   = 0;
	logic lvl = 1'b0;

	// Kick line level, one driver only
	assign kick = lvl;
	// Toggle the line once per gap, as a busy processor would
	always @(negedge clock) begin
		n <= (n >= gap) ? 0 : n + 1;
		if (gap != 8'h00 && n >= gap)
			lvl <= ~lvl;
	end
endmodule
